// [psc_pkg.sv]
// Package for the three-instance PWM slice block: register map, field
// positions, reset values and slice mode codes.
// Assumes byte-wide registers at their printed byte addresses.
package psc_pkg;

  localparam int          PSC_NUM         = 3;
  localparam logic [11:0] PSC_BASE        = 12'h460;
  localparam logic [11:0] PSC_STRIDE      = 12'h00f;
  localparam logic [11:0] PSC_OFF_PR_LO   = 12'h003;
  localparam logic [11:0] PSC_OFF_PR_HI   = 12'h004;
  localparam logic [11:0] PSC_OFF_CLOCK_PRESCALE    = 12'h005;
  localparam logic [11:0] PSC_OFF_CON     = 12'h009;
  localparam logic [11:0] PSC_OFF_CFG     = 12'h00a;
  localparam logic [11:0] PSC_OFF_P1_LO   = 12'h00b;
  localparam logic [11:0] PSC_OFF_P1_HI   = 12'h00c;
  localparam logic [11:0] PSC_OFF_P2_LO   = 12'h00d;
  localparam logic [11:0] PSC_OFF_P2_HI   = 12'h00e;
  localparam logic [11:0] PSC_ADDR_RELOAD = 12'h499;
  localparam logic [11:0] PSC_ADDR_ENABLE = 12'h49a;

  // Control register fields.
  localparam int CON_EN      = 7;
  localparam int CON_LD      = 2;
  localparam int CON_EXT_POL = 1;
  localparam int CON_EXT_IMM = 0;
  // Slice configuration fields.
  localparam int CFG_POL_TWO = 7;
  localparam int CFG_POL_ONE = 6;
  localparam int CFG_PP      = 3;
  localparam int CFG_MODE_LO = 0;

  localparam logic [7:0]  PSC_RST_BYTE = 8'h00;
  localparam logic [15:0] PSC_RST_WORD = 16'h0000;

  typedef enum logic [2:0] {
    PSC_LEFT     = 3'h0,
    PSC_RIGHT    = 3'h1,
    PSC_CENTER   = 3'h2,
    PSC_VARIABLE = 3'h3,
    PSC_CMP_SET  = 3'h4,
    PSC_CMP_TOG  = 3'h5,
    PSC_RSVD_A   = 3'h6,
    PSC_RSVD_B   = 3'h7
  } psc_mode_t;

endpackage : psc_pkg

// [psc_pwm.sv]
// Three PWM instances, each with one slice of two outputs, plus the
// global reload and enable mirror registers.
// Assumes a plain byte register port synchronous to REF_CLK and
// external stop inputs already synchronous to REF_CLK.
// Notes on behaviour
// - Reload bit copies buffers at period, self-clears
// - Stop polarity bit one means active low
// - Immediate stop halts on next PWM clock
// - Deferred stop halts at period end
// - Output two polarity bit inverts it
// - Output one polarity bit inverts it
// - Push-pull alternates outputs each period
// - Mode field selects alignment for both outputs
// - Mode 100 sets output high on match
// - Mode 101 toggles output on match
// - Reserved modes force outputs to reset
// - Compare modes signal match on equality
// - Variable mode: on at one, off at two
// - Center mode active twice parameter, centered
// - Right mode active parameter at period end
// - Left mode active parameter at period start
// - Parameters accessed as reset-zero byte halves
// - Global reload mirrors all reload bits
// - Global enable mirrors all enable bits
// - Disable resets logic, keeps register contents
// - PWM clock is source over prescale plus one
// - Period value counts PWM clocks per period
`timescale 1ns/100ps
module psc_pwm (
  // Clock and reset.
  input  wire  logic                          REF_CLK,
  input  wire  logic                          RST_N,
  // Register port.
  input  wire  logic [11:0]                   ADDR,
  input  wire  logic [7:0]                    WR_DATA,
  input  wire  logic                          WR_EN,
  input  wire  logic                          RD_EN,
  output logic       [7:0]                    RD_DATA,
  // External stop inputs, one per instance.
  input  wire  logic [psc_pkg::PSC_NUM-1:0]   EXT_STOP,
  // Slice outputs and match events, one per instance.
  output logic       [psc_pkg::PSC_NUM-1:0]   OUT_ONE,
  output logic       [psc_pkg::PSC_NUM-1:0]   OUT_TWO,
  output logic       [psc_pkg::PSC_NUM-1:0]   MATCH_ONE,
  output logic       [psc_pkg::PSC_NUM-1:0]   MATCH_TWO
);
  import psc_pkg::*;

  function automatic logic [11:0] reg_addr(input int idx, input logic [11:0] off);
    reg_addr = PSC_BASE + 12'(idx) * PSC_STRIDE + off;
  endfunction : reg_addr

  // Aligned-mode activity of one output for timer t, parameter p, period pr.
  function automatic logic align_act(input psc_mode_t m, input logic [15:0] t,
                                     input logic [15:0] p, input logic [15:0] pr);
    logic early;
    logic late;
    early = t < p;
    late  = ({1'b0, t} + {1'b0, p}) >= {1'b0, pr};
    unique case (m)
      PSC_LEFT:   align_act = early;
      PSC_RIGHT:  align_act = late;
      PSC_CENTER: align_act = early | late;
      default:    align_act = 1'b0;
    endcase
  endfunction : align_act

  logic [PSC_NUM-1:0]       en_reg, ld_reg, ext_pol_reg, ext_imm_reg;
  logic [PSC_NUM-1:0][7:0]  cfg_reg, clock_prescale_reg, pre_cnt_reg;
  logic [PSC_NUM-1:0][15:0] pr_reg, p1_reg, p2_reg;
  logic [PSC_NUM-1:0][15:0] pr_act_reg, p1_act_reg, p2_act_reg, tmr_reg;
  logic [PSC_NUM-1:0]       halt_reg, stop_pend_reg, phase_reg;
  logic [PSC_NUM-1:0]       st_one_reg, st_two_reg, var_reg;
  logic [PSC_NUM-1:0]       out_one_reg, out_two_reg, m_one_reg, m_two_reg;
  logic [7:0]               rd_data_reg;

  logic [PSC_NUM-1:0] tick, pev, stop_act, run, eq_one, eq_two;
  logic [PSC_NUM-1:0] wr_con, wr_ld_mirror, wr_en_mirror, set_ld;
  psc_mode_t          mode [PSC_NUM];

  // Decode and per-instance strobes.
  always_comb
  begin
    for (int i = 0; i < PSC_NUM; i++)
    begin
      mode[i]         = psc_mode_t'(cfg_reg[i][CFG_MODE_LO +: 3]);
      wr_con[i]       = WR_EN && (ADDR == reg_addr(i, PSC_OFF_CON));
      wr_ld_mirror[i] = WR_EN && (ADDR == PSC_ADDR_RELOAD);
      wr_en_mirror[i] = WR_EN && (ADDR == PSC_ADDR_ENABLE);
      set_ld[i]       = (wr_con[i] && WR_DATA[CON_LD]) ||
                        (wr_ld_mirror[i] && WR_DATA[i]);
      tick[i]         = en_reg[i] && (pre_cnt_reg[i] == clock_prescale_reg[i]);
      run[i]          = en_reg[i] && !halt_reg[i];
      pev[i]          = run[i] && tick[i] &&
                        ((tmr_reg[i] + 16'h0001 >= pr_act_reg[i]) ||
                         (pr_act_reg[i] == PSC_RST_WORD));
      stop_act[i]     = EXT_STOP[i] ^ ext_pol_reg[i];
      eq_one[i]       = run[i] && tick[i] && (tmr_reg[i] == p1_act_reg[i]);
      eq_two[i]       = run[i] && tick[i] && (tmr_reg[i] == p2_act_reg[i]);
    end
  end

  // Software-owned register contents; disable does not touch them.
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      en_reg      <= '0;
      ext_pol_reg <= '0;
      ext_imm_reg <= '0;
      cfg_reg     <= '0;
      clock_prescale_reg    <= '0;
      pr_reg      <= '0;
      p1_reg      <= '0;
      p2_reg      <= '0;
    end
    else
    begin
      for (int i = 0; i < PSC_NUM; i++)
      begin
        if (wr_con[i])
        begin
          en_reg[i]      <= WR_DATA[CON_EN];
          ext_pol_reg[i] <= WR_DATA[CON_EXT_POL];
          ext_imm_reg[i] <= WR_DATA[CON_EXT_IMM];
        end
        if (wr_en_mirror[i])
          en_reg[i] <= WR_DATA[i];
        // Configuration writes while enabled are taken as-is.
        if (WR_EN && ADDR == reg_addr(i, PSC_OFF_CFG))
          cfg_reg[i] <= WR_DATA;
        if (WR_EN && ADDR == reg_addr(i, PSC_OFF_CLOCK_PRESCALE))
          clock_prescale_reg[i] <= WR_DATA;
        if (WR_EN && ADDR == reg_addr(i, PSC_OFF_PR_LO))
          pr_reg[i][7:0] <= WR_DATA;
        if (WR_EN && ADDR == reg_addr(i, PSC_OFF_PR_HI))
          pr_reg[i][15:8] <= WR_DATA;
        if (WR_EN && ADDR == reg_addr(i, PSC_OFF_P1_LO))
          p1_reg[i][7:0] <= WR_DATA;
        if (WR_EN && ADDR == reg_addr(i, PSC_OFF_P1_HI))
          p1_reg[i][15:8] <= WR_DATA;
        if (WR_EN && ADDR == reg_addr(i, PSC_OFF_P2_LO))
          p2_reg[i][7:0] <= WR_DATA;
        if (WR_EN && ADDR == reg_addr(i, PSC_OFF_P2_HI))
          p2_reg[i][15:8] <= WR_DATA;
      end
    end
  end

  // Reload request: a new set wins over the completion clear.
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      ld_reg <= '0;
    else
    begin
      for (int i = 0; i < PSC_NUM; i++)
      begin
        if (set_ld[i])
          ld_reg[i] <= 1'b1;
        else if (pev[i] && ld_reg[i])
          ld_reg[i] <= 1'b0;
        else if (wr_con[i] || (wr_ld_mirror[i]))
          ld_reg[i] <= 1'b0;
      end
    end
  end

  // Active buffers follow the registers while disabled, so the first
  // period after enable already uses the programmed values.
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      pr_act_reg <= '0;
      p1_act_reg <= '0;
      p2_act_reg <= '0;
    end
    else
    begin
      for (int i = 0; i < PSC_NUM; i++)
      begin
        if (!en_reg[i] || (pev[i] && ld_reg[i]))
        begin
          pr_act_reg[i] <= pr_reg[i];
          p1_act_reg[i] <= p1_reg[i];
          p2_act_reg[i] <= p2_reg[i];
        end
      end
    end
  end

  // Prescaler and timer.
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      pre_cnt_reg <= '0;
      tmr_reg     <= '0;
      phase_reg   <= '0;
    end
    else
    begin
      for (int i = 0; i < PSC_NUM; i++)
      begin
        if (!en_reg[i])
        begin
          pre_cnt_reg[i] <= PSC_RST_BYTE;
          tmr_reg[i]     <= PSC_RST_WORD;
          phase_reg[i]   <= 1'b0;
        end
        else
        begin
          pre_cnt_reg[i] <= tick[i] ? PSC_RST_BYTE : pre_cnt_reg[i] + 8'h01;
          if (halt_reg[i])
            tmr_reg[i] <= PSC_RST_WORD;
          else if (pev[i])
          begin
            tmr_reg[i]   <= PSC_RST_WORD;
            phase_reg[i] <= ~phase_reg[i];
          end
          else if (tick[i])
            tmr_reg[i] <= tmr_reg[i] + 16'h0001;
        end
      end
    end
  end

  // External stop. A deferred stop is remembered until the period ends;
  // the halt lifts once the stop input is no longer active.
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      halt_reg      <= '0;
      stop_pend_reg <= '0;
    end
    else
    begin
      for (int i = 0; i < PSC_NUM; i++)
      begin
        if (!en_reg[i])
        begin
          halt_reg[i]      <= 1'b0;
          stop_pend_reg[i] <= 1'b0;
        end
        else if (halt_reg[i])
        begin
          stop_pend_reg[i] <= 1'b0;
          if (!stop_act[i])
            halt_reg[i] <= 1'b0;
        end
        else if (ext_imm_reg[i])
        begin
          stop_pend_reg[i] <= 1'b0;
          if (stop_act[i] && tick[i])
            halt_reg[i] <= 1'b1;
        end
        else
        begin
          if (pev[i] && (stop_pend_reg[i] || stop_act[i]))
          begin
            halt_reg[i]      <= 1'b1;
            stop_pend_reg[i] <= 1'b0;
          end
          else if (stop_act[i])
            stop_pend_reg[i] <= 1'b1;
        end
      end
    end
  end

  // Latched states for compare and variable modes.
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      st_one_reg <= '0;
      st_two_reg <= '0;
      var_reg    <= '0;
    end
    else
    begin
      for (int i = 0; i < PSC_NUM; i++)
      begin
        if (!en_reg[i])
        begin
          st_one_reg[i] <= 1'b0;
          st_two_reg[i] <= 1'b0;
          var_reg[i]    <= 1'b0;
        end
        else
        begin
          if (mode[i] == PSC_CMP_SET)
          begin
            if (eq_one[i])
              st_one_reg[i] <= 1'b1;
            if (eq_two[i])
              st_two_reg[i] <= 1'b1;
          end
          else if (mode[i] == PSC_CMP_TOG)
          begin
            if (eq_one[i])
              st_one_reg[i] <= ~st_one_reg[i];
            if (eq_two[i])
              st_two_reg[i] <= ~st_two_reg[i];
          end
          // The off point wins if both parameters are equal.
          if (eq_two[i])
            var_reg[i] <= 1'b0;
          else if (eq_one[i])
            var_reg[i] <= 1'b1;
        end
      end
    end
  end

  // Output stage: activity by mode, push-pull gating, then polarity.
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      out_one_reg <= '0;
      out_two_reg <= '0;
      m_one_reg   <= '0;
      m_two_reg   <= '0;
    end
    else
    begin
      for (int i = 0; i < PSC_NUM; i++)
      begin
        logic a1;
        logic a2;
        a1 = 1'b0;
        a2 = 1'b0;
        unique case (mode[i])
          PSC_LEFT, PSC_RIGHT, PSC_CENTER:
          begin
            a1 = align_act(mode[i], tmr_reg[i], p1_act_reg[i], pr_act_reg[i]);
            a2 = align_act(mode[i], tmr_reg[i], p2_act_reg[i], pr_act_reg[i]);
          end
          PSC_VARIABLE:
          begin
            a1 = var_reg[i];
            a2 = var_reg[i];
          end
          PSC_CMP_SET, PSC_CMP_TOG:
          begin
            a1 = st_one_reg[i];
            a2 = st_two_reg[i];
          end
          PSC_RSVD_A, PSC_RSVD_B:
          begin
            a1 = 1'b0;
            a2 = 1'b0;
          end
        endcase
        if (cfg_reg[i][CFG_PP])
        begin
          a1 = a1 && !phase_reg[i];
          a2 = a2 && phase_reg[i];
        end
        if (!run[i])
        begin
          a1 = 1'b0;
          a2 = 1'b0;
        end
        if (mode[i] == PSC_RSVD_A || mode[i] == PSC_RSVD_B)
        begin
          out_one_reg[i] <= 1'b0;
          out_two_reg[i] <= 1'b0;
        end
        else
        begin
          out_one_reg[i] <= a1 ^ cfg_reg[i][CFG_POL_ONE];
          out_two_reg[i] <= a2 ^ cfg_reg[i][CFG_POL_TWO];
        end
        m_one_reg[i] <= eq_one[i] && (mode[i] inside {PSC_VARIABLE, PSC_CMP_SET,
                                                       PSC_CMP_TOG});
        m_two_reg[i] <= eq_two[i] && (mode[i] inside {PSC_VARIABLE, PSC_CMP_SET,
                                                       PSC_CMP_TOG});
      end
    end
  end

  // Read port: data stand in the cycle after the strobe; unmapped reads 0.
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      rd_data_reg <= '0;
    else if (RD_EN)
    begin
      rd_data_reg <= PSC_RST_BYTE;
      if (ADDR == PSC_ADDR_RELOAD)
        rd_data_reg <= {5'h00, ld_reg};
      if (ADDR == PSC_ADDR_ENABLE)
        rd_data_reg <= {5'h00, en_reg};
      for (int i = 0; i < PSC_NUM; i++)
      begin
        if (ADDR == reg_addr(i, PSC_OFF_CON))
          rd_data_reg <= {en_reg[i], 4'h0, ld_reg[i], ext_pol_reg[i], ext_imm_reg[i]};
        if (ADDR == reg_addr(i, PSC_OFF_CFG))
          rd_data_reg <= cfg_reg[i] & 8'hcf;
        if (ADDR == reg_addr(i, PSC_OFF_CLOCK_PRESCALE))
          rd_data_reg <= clock_prescale_reg[i];
        if (ADDR == reg_addr(i, PSC_OFF_PR_LO))
          rd_data_reg <= pr_reg[i][7:0];
        if (ADDR == reg_addr(i, PSC_OFF_PR_HI))
          rd_data_reg <= pr_reg[i][15:8];
        if (ADDR == reg_addr(i, PSC_OFF_P1_LO))
          rd_data_reg <= p1_reg[i][7:0];
        if (ADDR == reg_addr(i, PSC_OFF_P1_HI))
          rd_data_reg <= p1_reg[i][15:8];
        if (ADDR == reg_addr(i, PSC_OFF_P2_LO))
          rd_data_reg <= p2_reg[i][7:0];
        if (ADDR == reg_addr(i, PSC_OFF_P2_HI))
          rd_data_reg <= p2_reg[i][15:8];
      end
    end
  end

  assign RD_DATA   = rd_data_reg;
  assign OUT_ONE   = out_one_reg;
  assign OUT_TWO   = out_two_reg;
  assign MATCH_ONE = m_one_reg;
  assign MATCH_TWO = m_two_reg;

  // Checks on instance zero.
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  sequence s_reload_due;
    pev[0] && ld_reg[0] && !set_ld[0];
  endsequence
  sequence s_quiet;
    !WR_EN;
  endsequence

  a_reload_clears: assert property (s_reload_due |=> !ld_reg[0])
    else $error("reload request not cleared at period event");
  a_reload_copies: assert property (s_reload_due ##0 s_quiet |=>
      p1_act_reg[0] == $past(p1_reg[0]) && pr_act_reg[0] == $past(pr_reg[0]))
    else $error("buffers not loaded at period event");
  a_stop_now: assert property (run[0] && ext_imm_reg[0] && stop_act[0] && tick[0]
      ##0 s_quiet |=> halt_reg[0] ##1 !OUT_ONE[0] || cfg_reg[0][CFG_POL_ONE]
      || mode[0] inside {PSC_RSVD_A, PSC_RSVD_B})
    else $error("immediate stop did not halt");
  a_stop_deferred: assert property (run[0] && !ext_imm_reg[0] && !pev[0]
      ##0 s_quiet |=> !halt_reg[0])
    else $error("deferred stop halted before period end");
  a_reserved_reset: assert property (mode[0] inside {PSC_RSVD_A, PSC_RSVD_B}
      |=> !OUT_ONE[0] && !OUT_TWO[0])
    else $error("reserved mode drove an output");
  a_disable_clears: assert property (!en_reg[0] |=> tmr_reg[0] == 16'h0000
      && !halt_reg[0])
    else $error("disabled instance kept running state");
  a_prescale_gap: assert property (tick[0] && clock_prescale_reg[0] == 8'h01 ##0 s_quiet
      |=> !tick[0] ##1 tick[0] || !en_reg[0])
    else $error("prescaler divide wrong");
  a_match_pulse: assert property (eq_one[0] && mode[0] == PSC_CMP_SET
      |=> MATCH_ONE[0] ##1 OUT_ONE[0] != cfg_reg[0][CFG_POL_ONE] || WR_EN)
    else $error("compare match not signalled");
  a_toggle_flip: assert property (eq_one[0] && mode[0] == PSC_CMP_TOG ##0 s_quiet
      |=> st_one_reg[0] != $past(st_one_reg[0]))
    else $error("compare toggle missed");
  a_wrap_zero: assert property (pev[0] ##0 s_quiet |=> tmr_reg[0] == 16'h0000)
    else $error("timer did not wrap");

endmodule : psc_pwm

// [pwm_slice_config_and_sync_bench.sv]
// Self-checking bench for the three-instance PWM slice block.
// Assumes psc_pkg and psc_pwm are compiled before this file.
`timescale 1ns/100ps
module pwm_slice_config_and_sync_bench;
  import psc_pkg::*;

  logic        clk;
  logic        rst_n;
  logic [11:0] addr;
  logic [7:0]  wdat;
  logic        wen;
  logic        ren;
  logic [7:0]  rdat;
  logic [2:0]  stop;
  logic [2:0]  o1;
  logic [2:0]  o2;
  logic [2:0]  m1;
  logic [2:0]  m2;
  logic [15:0] seed;
  logic [15:0] p1;
  logic [15:0] p2;
  logic [11:0] a;
  logic [7:0]  v;
  logic [2:0]  md;
  logic        pl;
  int          n_mismatch;
  int          compares;
  int          cyc;

  psc_pwm i_dut (
    .REF_CLK   (clk),
    .RST_N     (rst_n),
    .ADDR      (addr),
    .WR_DATA   (wdat),
    .WR_EN     (wen),
    .RD_EN     (ren),
    .RD_DATA   (rdat),
    .EXT_STOP  (stop),
    .OUT_ONE   (o1),
    .OUT_TWO   (o2),
    .MATCH_ONE (m1),
    .MATCH_TWO (m2)
  );

  always #5 clk = ~clk;

  // The whole run needs about 2500 cycles; the ceiling leaves ample margin.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (n_mismatch == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  function automatic logic [11:0] ra(input int i, input logic [11:0] off);
    return PSC_BASE + PSC_STRIDE * 12'(i) + off;
  endfunction : ra

  // High cycles per period for the aligned modes, inverted when low true.
  function automatic int exph(input logic [2:0] m, input int pr, input int p, input logic pol);
    int h;
    h = (m == PSC_CENTER) ? 2 * p : p;
    return pol ? pr - h : h;
  endfunction : exph

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] ad, input logic [7:0] d);
    @(posedge clk);
    addr <= ad;
    wdat <= d;
    wen  <= 1'b1;
    @(posedge clk);
    wen  <= 1'b0;
  endtask : wr

  task automatic rchk(input logic [11:0] ad, input logic [7:0] e);
    @(posedge clk);
    addr <= ad;
    ren  <= 1'b1;
    @(posedge clk);
    ren  <= 1'b0;
    #1;
    chk({8'h00, rdat}, {8'h00, e});
  endtask : rchk

  // Counts high samples of one output kind over n cycles and compares.
  task automatic cc(input int i, input int s, input int n, input int e);
    logic [2:0] w;
    int         k;
    k = 0;
    repeat (n)
    begin
      @(posedge clk);
      #1;
      w = (s == 0) ? o1 : (s == 1) ? o2 : (s == 2) ? m1 : m2;
      if (w[i] === 1'b1)
        k++;
    end
    chk(16'(k), 16'(e));
  endtask : cc

  task automatic wait_rise(input int i);
    logic p;
    int   t;
    p = 1'b1;
    t = 0;
    while (t < 300 && !(p === 1'b0 && o1[i] === 1'b1))
    begin
      p = o1[i];
      @(posedge clk);
      #1;
      t++;
    end
    chk(16'(t == 300), 16'h0000);
  endtask : wait_rise

  // Configuration is only written while the instance is disabled.
  task automatic setup(input int i, input logic [15:0] pr, input logic [15:0] q1,
                       input logic [15:0] q2, input logic [7:0] cf, input logic [7:0] con);
    wr(ra(i, PSC_OFF_CON), 8'h00);
    wr(ra(i, PSC_OFF_PR_LO), pr[7:0]);
    wr(ra(i, PSC_OFF_PR_HI), pr[15:8]);
    wr(ra(i, PSC_OFF_CLOCK_PRESCALE), 8'h00);
    wr(ra(i, PSC_OFF_CFG), cf);
    wr(ra(i, PSC_OFF_P1_LO), q1[7:0]);
    wr(ra(i, PSC_OFF_P1_HI), q1[15:8]);
    wr(ra(i, PSC_OFF_P2_LO), q2[7:0]);
    wr(ra(i, PSC_OFF_P2_HI), q2[15:8]);
    wr(ra(i, PSC_OFF_CON), con);
    repeat (25) @(posedge clk);
  endtask : setup

  initial
  begin
    clk   = 1'b0;
    rst_n = 1'b0;
    addr  = 12'h000;
    wdat  = 8'h00;
    wen   = 1'b0;
    ren   = 1'b0;
    stop  = 3'h0;
    seed  = 16'h8045;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 3; i++)
      for (int k = 9; k < 15; k++)
        rchk(ra(i, 12'(k)), 8'h00);
    rchk(PSC_ADDR_RELOAD, 8'h00);
    rchk(PSC_ADDR_ENABLE, 8'h00);
    wr(12'h48d, 8'h5a);
    rchk(12'h48d, 8'h00);
    wr(ra(1, PSC_OFF_CFG), 8'hff);
    rchk(ra(1, PSC_OFF_CFG), 8'hcf);
    for (int k = 0; k < 24; k++)
    begin
      seed = lfsr(seed);
      a = ra(k % 3, 12'(11 + (k / 3) % 4));
      wr(a, seed[7:0]);
      rchk(a, seed[7:0]);
    end
    for (int k = 0; k < 6; k++)
    begin
      seed = lfsr(seed);
      p1 = {14'h0000, seed[1:0]} + 16'h0001;
      p2 = {14'h0000, seed[3:2]} + 16'h0001;
      md = 3'(k / 2);
      pl = k[0];
      setup(k % 3, 16'h000a, p1, p2, {pl, pl, 3'h0, md}, 8'h80);
      cc(k % 3, 0, 10, exph(md, 10, int'(p1), pl));
      cc(k % 3, 1, 10, exph(md, 10, int'(p2), pl));
    end
    setup(1, 16'h000a, 16'h0002, 16'h0007, {5'h00, PSC_VARIABLE}, 8'h80);
    cc(1, 0, 10, 5);
    cc(1, 1, 10, 5);
    cc(1, 2, 10, 1);
    cc(1, 3, 10, 1);
    // Compare modes run on instance zero so that the built-in checks see them.
    setup(0, 16'h000a, 16'h0004, 16'h0006, {5'h00, PSC_CMP_SET}, 8'h80);
    cc(0, 0, 10, 10);
    cc(0, 1, 10, 10);
    cc(0, 3, 10, 1);
    setup(0, 16'h000a, 16'h0004, 16'h0006, {5'h00, PSC_CMP_TOG}, 8'h80);
    #1;
    v[0] = o1[0];
    repeat (10) @(posedge clk);
    #1;
    chk({15'h0000, o1[0]}, {15'h0000, ~v[0]});
    for (int k = 6; k < 8; k++)
    begin
      setup(0, 16'h000a, 16'h0003, 16'h0003, 8'hc0 | 8'(k), 8'h80);
      cc(0, 0, 10, 0);
      cc(0, 1, 10, 0);
    end
    setup(1, 16'h000a, 16'h0003, 16'h0003, 8'h08, 8'h80);
    cc(1, 0, 20, 3);
    cc(1, 1, 20, 3);
    wr(ra(0, PSC_OFF_CLOCK_PRESCALE), 8'h01);
    setup(0, 16'h000a, 16'h0003, 16'h0000, 8'h00, 8'h80);
    wr(ra(0, PSC_OFF_CON), 8'h00);
    wr(ra(0, PSC_OFF_CLOCK_PRESCALE), 8'h01);
    wr(ra(0, PSC_OFF_CON), 8'h80);
    repeat (40) @(posedge clk);
    cc(0, 0, 20, 6);
    setup(0, 16'h0064, 16'h0014, 16'h0000, 8'h00, 8'h80);
    wait_rise(0);
    wr(ra(0, PSC_OFF_P1_LO), 8'h32);
    cc(0, 0, 100, 20);
    wait_rise(0);
    wr(ra(0, PSC_OFF_CON), 8'h84);
    rchk(ra(0, PSC_OFF_CON), 8'h84);
    repeat (100) @(posedge clk);
    rchk(ra(0, PSC_OFF_CON), 8'h80);
    cc(0, 0, 100, 50);
    setup(1, 16'h0064, 16'h0014, 16'h0000, 8'h00, 8'h80);
    setup(2, 16'h0064, 16'h0014, 16'h0000, 8'h00, 8'h80);
    wr(PSC_ADDR_ENABLE, 8'h00);
    rchk(ra(1, PSC_OFF_CON), 8'h00);
    wr(PSC_ADDR_ENABLE, 8'h06);
    rchk(ra(2, PSC_OFF_CON), 8'h80);
    rchk(PSC_ADDR_ENABLE, 8'h06);
    wait_rise(1);
    wr(ra(1, PSC_OFF_P1_LO), 8'h32);
    wr(ra(2, PSC_OFF_P1_LO), 8'h32);
    wr(PSC_ADDR_RELOAD, 8'h06);
    rchk(PSC_ADDR_RELOAD, 8'h06);
    rchk(ra(2, PSC_OFF_CON), 8'h84);
    repeat (100) @(posedge clk);
    rchk(PSC_ADDR_RELOAD, 8'h00);
    cc(1, 0, 100, 50);
    cc(2, 0, 100, 50);
    wr(PSC_ADDR_ENABLE, 8'h00);
    cc(2, 0, 100, 0);
    rchk(ra(2, PSC_OFF_P1_LO), 8'h32);
    setup(0, 16'h000a, 16'h0005, 16'h0000, 8'h00, 8'h81);
    wait_rise(0);
    @(posedge clk);
    stop[0] <= 1'b1;
    repeat (3) @(posedge clk);
    cc(0, 0, 10, 0);
    @(posedge clk);
    stop[0] <= 1'b0;
    repeat (25) @(posedge clk);
    cc(0, 0, 10, 5);
    @(posedge clk);
    stop[0] <= 1'b1;
    setup(0, 16'h000a, 16'h0005, 16'h0000, 8'h00, 8'h83);
    cc(0, 0, 10, 5);
    @(posedge clk);
    stop[0] <= 1'b0;
    repeat (3) @(posedge clk);
    cc(0, 0, 10, 0);
    setup(0, 16'h000a, 16'h0005, 16'h0000, 8'h00, 8'h80);
    wait_rise(0);
    @(posedge clk);
    stop[0] <= 1'b1;
    cc(0, 0, 3, 3);
    repeat (10) @(posedge clk);
    cc(0, 0, 10, 0);
    finish_test();
  end
endmodule : pwm_slice_config_and_sync_bench
